// [hw/csc_converter.sv]
`timescale 1ns/1ps
module csc_converter (
  input wire logic clk,
  input wire logic reset,
  csc_if.conv link,
  input wire logic [csc_pkg::CSC_RES_W-1:0] sample_in,
  output logic [3:0] channel
);
  import csc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SAMPLE, ST_CONV, ST_HALT, ST_WEDGE, ST_HANG
  } csc_state_t;

  csc_state_t state_r, state_nxt;
  logic [2:0] div_cnt_r, div_cnt_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [CSC_RES_W-1:0] result_r, result_nxt;
  logic armed_r, armed_nxt;
  logic off_seen_r, off_seen_nxt;
  logic last_timer_r, last_timer_nxt;
  logic collected_r, collected_nxt;
  logic stuck_r, stuck_nxt;
  logic enc_d_r, pon_d_r, start_d_r, dma_en_d_r;
  logic [1:0] ssel_d_r;
  logic tick, start_rise, trig, multi, conv_end, seq_last, hang_hit, wedge_hit;
  logic start_clear_c, dma_req_c, seq_end_c;

  // ==========================================
  // converter clock enable and trigger decode
  assign tick = (div_cnt_r == link.div);
  assign start_rise = link.start && !start_d_r;
  assign trig = link.timer_sel ? link.timer_trig : start_rise;
  assign multi = (link.seq_mode != CSC_SINGLE);
  assign conv_end = (state_r == ST_CONV) && tick && (cnt_r == {4'h0, CSC_CONV_CLKS - 4'h1});
  assign seq_last = (link.seq_mode == CSC_SINGLE) || (link.seq_mode == CSC_REP_SINGLE)
                    || (chan_r == link.seq_len);
  // a gated source abandoned on an odd divider leaves the divider unrecoverable
  assign hang_hit = (ssel_d_r == CSC_SSEL_SUBSYS) && (link.ssel != CSC_SSEL_SUBSYS)
                    && link.clk_gate_off && CSC_ODD_DIV_MASK[link.div];
  assign wedge_hit = link.enc && !enc_d_r && start_rise && last_timer_r;

  // ==========================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    div_cnt_nxt = tick ? 3'h0 : div_cnt_r + 3'h1;
    cnt_nxt = cnt_r;
    chan_nxt = chan_r;
    result_nxt = result_r;
    armed_nxt = armed_r;
    off_seen_nxt = off_seen_r;
    last_timer_nxt = last_timer_r;
    collected_nxt = collected_r || link.cpu_read;
    stuck_nxt = stuck_r;
    start_clear_c = 1'b0;
    dma_req_c = 1'b0;
    seq_end_c = 1'b0;
    // falling enable re-arms the external trigger path
    if (!link.enc && enc_d_r) begin
      armed_nxt = 1'b1;
    end
    // edge-mode dma after cpu collection loses its trigger
    if (link.dma_en && !dma_en_d_r && !link.dma_level && collected_r) begin
      stuck_nxt = 1'b1;
      collected_nxt = 1'b0;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (link.enc && link.pon) begin
          if (wedge_hit) begin
            state_nxt = ST_WEDGE;
            off_seen_nxt = 1'b0;
          end else if (link.timer_sel && link.timer_trig && !armed_r) begin
            state_nxt = ST_HALT;
            off_seen_nxt = 1'b0;
          end else if (link.timer_sel ? link.timer_trig : link.start) begin
            state_nxt = ST_SAMPLE;
            cnt_nxt = 8'h00;
            chan_nxt = 4'h0;
            last_timer_nxt = link.timer_sel;
            start_clear_c = !link.timer_sel;
          end
        end
      end
      ST_SAMPLE, ST_CONV: begin
        // overrun and power toggle are not flagged as overflow
        if (multi && (trig || (link.pon != pon_d_r))) begin
          state_nxt = ST_HALT;
          off_seen_nxt = 1'b0;
        end else if (state_r == ST_SAMPLE) begin
          if (tick) begin
            if (cnt_r + 8'h01 >= link.sample_clks) begin
              state_nxt = ST_CONV;
              cnt_nxt = 8'h00;
            end else begin
              cnt_nxt = cnt_r + 8'h01;
            end
          end
        end else if (tick) begin
          cnt_nxt = cnt_r + 8'h01;
          if (conv_end) begin
            result_nxt = sample_in;
            cnt_nxt = 8'h00;
            // one request per conversion, even inside a sequence
            dma_req_c = link.dma_en && !(stuck_r && !link.dma_level);
            if (link.dma_en && link.dma_level) begin
              stuck_nxt = 1'b0;
            end
            if (seq_last) begin
              seq_end_c = 1'b1;
              chan_nxt = 4'h0;
              if (link.seq_mode[1] && link.enc) begin
                state_nxt = ST_SAMPLE;
              end else begin
                state_nxt = ST_IDLE;
                if (link.timer_sel) begin
                  armed_nxt = 1'b0;
                end
              end
            end else begin
              chan_nxt = chan_r + 4'h1;
              state_nxt = ST_SAMPLE;
            end
          end
        end
      end
      ST_HALT, ST_WEDGE: begin
        // return to idle only after enable and power both seen low, then both high
        if (!link.enc && !link.pon) begin
          off_seen_nxt = 1'b1;
        end
        if (off_seen_r && link.enc && link.pon) begin
          state_nxt = ST_IDLE;
          armed_nxt = 1'b1;
          last_timer_nxt = 1'b0;
        end
      end
      ST_HANG: begin
        state_nxt = ST_HANG;
      end
    endcase
    if (hang_hit) begin
      state_nxt = ST_HANG;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      div_cnt_r <= 3'h0;
      cnt_r <= 8'h00;
      chan_r <= 4'h0;
      result_r <= '0;
      armed_r <= 1'b1;
      off_seen_r <= 1'b0;
      last_timer_r <= 1'b0;
      collected_r <= 1'b0;
      stuck_r <= 1'b0;
      enc_d_r <= 1'b0;
      pon_d_r <= 1'b0;
      start_d_r <= 1'b0;
      dma_en_d_r <= 1'b0;
      ssel_d_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      div_cnt_r <= div_cnt_nxt;
      cnt_r <= cnt_nxt;
      chan_r <= chan_nxt;
      result_r <= result_nxt;
      armed_r <= armed_nxt;
      off_seen_r <= off_seen_nxt;
      last_timer_r <= last_timer_nxt;
      collected_r <= collected_nxt;
      stuck_r <= stuck_nxt;
      enc_d_r <= link.enc;
      pon_d_r <= link.pon;
      start_d_r <= link.start;
      dma_en_d_r <= link.dma_en;
      ssel_d_r <= link.ssel;
    end
  end

  // ==========================================
  // outputs
  assign link.busy = (state_r == ST_SAMPLE) || (state_r == ST_CONV)
                     || (state_r == ST_WEDGE);
  assign link.start_clear = start_clear_c;
  assign link.dma_req = dma_req_c;
  assign link.seq_end = seq_end_c;
  assign link.conv_done = conv_end;
  assign link.result = result_r;
  assign link.halted = (state_r == ST_HALT) || (state_r == ST_WEDGE);
  assign link.hung = (state_r == ST_HANG);
  // extended sampling on an unbuffered reference needs six clocks or more
  assign link.suspect = !link.shp && CSC_UNBUF_REF_MASK[link.vrsel]
                        && (link.sample_clks < CSC_MIN_SAFE_SAMPLE);
  assign link.stuck = stuck_r;
  assign link.tov = 1'b0;
  assign channel = chan_r;
endmodule

// [pkg/csc_pkg.sv]
package csc_pkg;
  // ==========================================
  // field codes
  typedef enum logic [1:0] {
    CSC_SINGLE = 2'h0,
    CSC_SEQ = 2'h1,
    CSC_REP_SINGLE = 2'h2,
    CSC_REP_SEQ = 2'h3
  } csc_mode_t;
  localparam logic [1:0] CSC_SSEL_SUBSYS = 2'h3;
  localparam logic [7:0] CSC_MIN_SAFE_SAMPLE = 8'h06;
  localparam logic [15:0] CSC_UNBUF_REF_MASK = 16'h5055;
  localparam logic [7:0] CSC_ODD_DIV_MASK = 8'h54;
  localparam int CSC_RES_W = 12;
  localparam logic [3:0] CSC_CONV_CLKS = 4'hD;
  // ==========================================
  // register map of the controller end
  localparam logic [7:0] CSC_A_CTRL = 8'h00;
  localparam logic [7:0] CSC_A_CFG = 8'h04;
  localparam logic [7:0] CSC_A_TIMER = 8'h08;
  localparam logic [7:0] CSC_A_STATUS = 8'h0C;
  localparam logic [7:0] CSC_A_RESULT = 8'h10;
  localparam logic [7:0] CSC_A_IRQ_STAT = 8'h14;
  localparam logic [7:0] CSC_A_IRQ_MASK = 8'h18;
  localparam int CSC_B_ENC = 0;
  localparam int CSC_B_PON = 1;
  localparam int CSC_B_START = 2;
  localparam int CSC_B_SHP = 3;
  localparam int CSC_B_TSEL = 4;
  localparam int CSC_B_DMAEN = 5;
  localparam int CSC_B_DMALVL = 6;
  localparam int CSC_B_GATE = 7;
  localparam int CSC_B_MODE = 8;
  localparam int CSC_B_VRSEL = 10;
  localparam int CSC_B_SSEL = 14;
  localparam int CSC_B_DIV = 16;
  localparam int CSC_B_TRUN = 16;
  localparam int CSC_B_SEQLEN = 8;
  localparam logic [31:0] CSC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CSC_CFG_RST = 32'h0000_0006;
  localparam logic [31:0] CSC_TIMER_RST = 32'h0000_0100;
  localparam int CSC_NIRQ = 4;
endpackage

// [pkg/csc_if.sv]
`timescale 1ns/1ps
interface csc_if;
  import csc_pkg::*;
  logic enc;
  logic pon;
  logic start;
  logic shp;
  logic timer_sel;
  logic timer_trig;
  csc_mode_t seq_mode;
  logic [3:0] seq_len;
  logic [3:0] vrsel;
  logic [1:0] ssel;
  logic [2:0] div;
  logic clk_gate_off;
  logic [7:0] sample_clks;
  logic dma_en;
  logic dma_level;
  logic cpu_read;
  logic busy;
  logic start_clear;
  logic dma_req;
  logic seq_end;
  logic conv_done;
  logic [CSC_RES_W-1:0] result;
  logic halted;
  logic hung;
  logic suspect;
  logic stuck;
  logic tov;
  modport conv (
    input enc, pon, start, shp, timer_sel, timer_trig, seq_mode, seq_len, vrsel,
    input ssel, div, clk_gate_off, sample_clks, dma_en, dma_level, cpu_read,
    output busy, start_clear, dma_req, seq_end, conv_done, result, halted,
    output hung, suspect, stuck, tov
  );
  modport ctl (
    output enc, pon, start, shp, timer_sel, timer_trig, seq_mode, seq_len, vrsel,
    output ssel, div, clk_gate_off, sample_clks, dma_en, dma_level, cpu_read,
    input busy, start_clear, dma_req, seq_end, conv_done, result, halted,
    input hung, suspect, stuck, tov
  );
endinterface

// [hw/csc_controller.sv]
`timescale 1ns/1ps
module csc_controller (
  input wire logic clk,
  input wire logic reset,
  csc_if.ctl link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output logic dma_valid,
  output logic [csc_pkg::CSC_RES_W-1:0] dma_data
);
  import csc_pkg::*;

  logic [31:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt, tmr_r, tmr_nxt, rdata_r, rdata_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [3:0] dcnt_r, dcnt_nxt;
  logic [CSC_NIRQ-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
  logic dma_valid_r, dma_valid_nxt, halted_d_r, dma_done;
  logic [CSC_RES_W-1:0] dma_data_r, dma_data_nxt;
  logic tpulse;

  // ==========================================
  // period timer for external triggers
  assign tpulse = tmr_r[CSC_B_TRUN] && (tcnt_r == tmr_r[15:0]);
  assign dma_done = link.dma_req && (dcnt_r == cfg_r[CSC_B_SEQLEN +: 4]);
  assign ev = {link.halted && !halted_d_r, dma_done, link.seq_end, link.conv_done};

  always_comb begin
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    tmr_nxt = tmr_r;
    imask_nxt = imask_r;
    rdata_nxt = 32'h0000_0000;
    tcnt_nxt = tpulse || !tmr_r[CSC_B_TRUN] ? 16'h0000 : tcnt_r + 16'h0001;
    dcnt_nxt = dcnt_r;
    dma_valid_nxt = link.dma_req;
    dma_data_nxt = link.dma_req ? link.result : dma_data_r;
    if (link.dma_req) begin
      dcnt_nxt = dma_done ? 4'h0 : dcnt_r + 4'h1;
    end
    ist_nxt = ist_r;
    if (link.start_clear) begin
      ctrl_nxt[CSC_B_START] = 1'b0;
    end
    if (wr) begin
      unique case (addr)
        CSC_A_CTRL: ctrl_nxt = wdata;
        CSC_A_CFG: cfg_nxt = wdata;
        CSC_A_TIMER: tmr_nxt = wdata;
        CSC_A_IRQ_STAT: ist_nxt = ist_r & ~wdata[CSC_NIRQ-1:0];
        CSC_A_IRQ_MASK: imask_nxt = wdata[CSC_NIRQ-1:0];
        default: ;
      endcase
    end
    // hardware set wins over a same-cycle write-one clear
    ist_nxt = ist_nxt | ev;
    if (rd) begin
      unique case (addr)
        CSC_A_CTRL: rdata_nxt = ctrl_r;
        CSC_A_CFG: rdata_nxt = cfg_r;
        CSC_A_TIMER: rdata_nxt = tmr_r;
        CSC_A_STATUS: rdata_nxt = {26'h0, link.tov, link.stuck, link.suspect,
                                   link.hung, link.halted, link.busy};
        CSC_A_RESULT: rdata_nxt = {20'h0, link.result};
        CSC_A_IRQ_STAT: rdata_nxt = {28'h0, ist_r};
        CSC_A_IRQ_MASK: rdata_nxt = {28'h0, imask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= CSC_CTRL_RST;
      cfg_r <= CSC_CFG_RST;
      tmr_r <= CSC_TIMER_RST;
      rdata_r <= 32'h0000_0000;
      tcnt_r <= 16'h0000;
      dcnt_r <= 4'h0;
      ist_r <= '0;
      imask_r <= '0;
      dma_valid_r <= 1'b0;
      dma_data_r <= '0;
      halted_d_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      tmr_r <= tmr_nxt;
      rdata_r <= rdata_nxt;
      tcnt_r <= tcnt_nxt;
      dcnt_r <= dcnt_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      dma_valid_r <= dma_valid_nxt;
      dma_data_r <= dma_data_nxt;
      halted_d_r <= link.halted;
    end
  end

  // ==========================================
  // drive the converter; software owns ordering
  assign link.enc = ctrl_r[CSC_B_ENC];
  assign link.pon = ctrl_r[CSC_B_PON];
  assign link.start = ctrl_r[CSC_B_START];
  assign link.shp = ctrl_r[CSC_B_SHP];
  assign link.timer_sel = ctrl_r[CSC_B_TSEL];
  assign link.dma_en = ctrl_r[CSC_B_DMAEN];
  assign link.dma_level = ctrl_r[CSC_B_DMALVL];
  assign link.clk_gate_off = ctrl_r[CSC_B_GATE];
  assign link.seq_mode = csc_mode_t'(ctrl_r[CSC_B_MODE +: 2]);
  assign link.vrsel = ctrl_r[CSC_B_VRSEL +: 4];
  assign link.ssel = ctrl_r[CSC_B_SSEL +: 2];
  assign link.div = ctrl_r[CSC_B_DIV +: 3];
  assign link.sample_clks = cfg_r[7:0];
  assign link.seq_len = cfg_r[CSC_B_SEQLEN +: 4];
  assign link.timer_trig = tpulse;
  assign link.cpu_read = rd && (addr == CSC_A_RESULT);
  assign rdata = rdata_r;
  assign irq = |(ist_r & imask_r);
  assign dma_valid = dma_valid_r;
  assign dma_data = dma_data_r;
endmodule

// [bench/csc_properties.sv]
`timescale 1ns/1ps
module csc_properties (
  input logic clk,
  input logic reset,
  input logic pon,
  input logic start,
  input logic shp,
  input csc_pkg::csc_mode_t seq_mode,
  input logic [3:0] vrsel,
  input logic [1:0] ssel,
  input logic [2:0] div,
  input logic clk_gate_off,
  input logic [7:0] sample_clks,
  input logic dma_en,
  input logic busy,
  input logic start_clear,
  input logic dma_req,
  input logic seq_end,
  input logic conv_done,
  input logic halted,
  input logic hung,
  input logic suspect,
  input logic stuck,
  input logic tov
);
  import csc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // properties
  property p_tov_quiet; tov == 1'b0; endproperty
  a_tov_quiet: assert property (p_tov_quiet) else $error("overflow flag raised");
  property p_start_busy; start_clear |=> busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not raised");
  property p_end_idle;
    seq_end && !halted && (seq_mode == CSC_SINGLE || seq_mode == CSC_SEQ) |=> !busy;
  endproperty
  a_end_idle: assert property (p_end_idle) else $error("busy after last conversion");
  property p_dma_each; conv_done && dma_en && !stuck |-> dma_req; endproperty
  a_dma_each: assert property (p_dma_each) else $error("dma request missing");
  property p_end_last; seq_end |-> conv_done; endproperty
  a_end_last: assert property (p_end_last) else $error("sequence end without conversion");
  // one cycle of slack: the trigger may be seen an edge later
  property p_overrun;
    $rose(start) && busy && !halted && seq_mode != CSC_SINGLE |-> ##[1:2] halted;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun did not halt");
  property p_pon_busy;
    $changed(pon) && busy && !halted && seq_mode != CSC_SINGLE |-> ##[1:2] halted;
  endproperty
  a_pon_busy: assert property (p_pon_busy) else $error("power toggle did not halt");
  property p_suspect;
    suspect == (!shp && CSC_UNBUF_REF_MASK[vrsel] && sample_clks < CSC_MIN_SAFE_SAMPLE);
  endproperty
  a_suspect: assert property (p_suspect) else $error("suspect flag wrong");
  property p_hang;
    $past(ssel) == CSC_SSEL_SUBSYS && ssel != CSC_SSEL_SUBSYS && clk_gate_off
      && div inside {3'h2, 3'h4, 3'h6} |=> hung;
  endproperty
  a_hang: assert property (p_hang) else $error("clock switch did not hang");
  property p_hang_hold; hung |=> hung; endproperty
  a_hang_hold: assert property (p_hang_hold) else $error("hang left without reset");
  c_seq_end: cover property (seq_end && seq_mode == CSC_SEQ);
  c_halt: cover property ($rose(halted));
  c_hang: cover property ($rose(hung));
endmodule

// [bench/converter_sequence_control_tb.sv]
`timescale 1ns/1ps
module converter_sequence_control_tb;
  import csc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic dma_valid;
  logic [11:0] dmad;
  logic [11:0] smp = 12'hA5C;
  int n_errors = 0;
  int total_checks = 0;
  int n_dma = 0;
  int n_end = 0;
  int n_val = 0;
  logic [31:0] v;
  csc_if lnk();
  csc_converter i_csc_converter (.clk(clk), .reset(reset), .link(lnk), .sample_in(smp),
    .channel());
  csc_controller i_csc_controller (.clk(clk), .reset(reset), .link(lnk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .dma_valid(dma_valid),
    .dma_data(dmad));
  csc_properties i_csc_properties (.clk(clk), .reset(reset), .pon(lnk.pon),
    .start(lnk.start), .shp(lnk.shp), .seq_mode(lnk.seq_mode), .vrsel(lnk.vrsel),
    .ssel(lnk.ssel), .div(lnk.div), .clk_gate_off(lnk.clk_gate_off),
    .sample_clks(lnk.sample_clks), .dma_en(lnk.dma_en), .busy(lnk.busy),
    .start_clear(lnk.start_clear), .dma_req(lnk.dma_req), .seq_end(lnk.seq_end),
    .conv_done(lnk.conv_done), .halted(lnk.halted), .hung(lnk.hung),
    .suspect(lnk.suspect), .stuck(lnk.stuck), .tov(lnk.tov));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (lnk.dma_req === 1'b1) n_dma++;
    if (lnk.seq_end === 1'b1) n_end++;
    if (dma_valid === 1'b1) n_val++;
  end
  // ==========================================
  // bus and checking
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic xreg(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(nm, e, v & m);
  endtask
  // polls like software would; a stuck busy ends the run
  task automatic wait_idle();
    for (int i = 0; i < 100; i++) begin
      xreg("poll", CSC_A_STATUS, 32'h0, 32'h0);
      if (v[0] === 1'b0) return;
    end
    chk("busy timeout", 32'h0, 32'h1);
    report_and_stop();
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_single();
    wreg(CSC_A_IRQ_MASK, 32'h1);
    wreg(CSC_A_CFG, 32'h6);
    wreg(CSC_A_CTRL, 32'h3);
    wreg(CSC_A_CTRL, 32'h7);
    wait_idle();
    xreg("result", CSC_A_RESULT, 32'hFFF, 32'hA5C);
    xreg("status", CSC_A_STATUS, 32'h3F, 32'h0);
    chk("irq set", 32'h1, {31'h0, irq});
    wreg(CSC_A_IRQ_STAT, 32'h1);
    xreg("irq_stat", CSC_A_IRQ_STAT, 32'hF, 32'h2);
    chk("irq clear", 32'h0, {31'h0, irq});
    xreg("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_seq();
    int d0;
    int e0;
    int q0;
    wreg(CSC_A_CFG, 32'h206);
    wreg(CSC_A_CTRL, 32'h163);
    d0 = n_dma;
    e0 = n_end;
    q0 = n_val;
    wreg(CSC_A_CTRL, 32'h167);
    wait_idle();
    chk("dma_req count", 32'd3, n_dma - d0);
    chk("dma_valid count", 32'd3, n_val - q0);
    chk("seq_end count", 32'd1, n_end - e0);
    xreg("dma done", CSC_A_IRQ_STAT, 32'hF, 32'h7);
    wreg(CSC_A_IRQ_STAT, 32'hF);
  endtask
  task automatic t_overrun();
    wreg(CSC_A_CTRL, 32'h167);
    repeat (4) @(posedge clk);
    wreg(CSC_A_CTRL, 32'h167);
    xreg("halted", CSC_A_STATUS, 32'h22, 32'h2);
    xreg("halt irq", CSC_A_IRQ_STAT, 32'h8, 32'h8);
    wreg(CSC_A_CTRL, 32'h160);
    wreg(CSC_A_CTRL, 32'h163);
    wreg(CSC_A_CTRL, 32'h167);
    wait_idle();
    xreg("recovered", CSC_A_STATUS, 32'h2, 32'h0);
  endtask
  task automatic t_pon();
    wreg(CSC_A_CTRL, 32'h263);
    wreg(CSC_A_CTRL, 32'h267);
    repeat (4) @(posedge clk);
    wreg(CSC_A_CTRL, 32'h261);
    xreg("pon halt", CSC_A_STATUS, 32'h2, 32'h2);
    do_reset();
  endtask
  task automatic t_suspect();
    wreg(CSC_A_CFG, 32'h4);
    for (int k = 0; k < 16; k++) begin
      wreg(CSC_A_CTRL, 32'h3 | (k << 10));
      xreg("suspect", CSC_A_STATUS, 32'h8, {28'h0, k inside {0, 2, 4, 6, 12, 14}, 3'h0});
    end
    wreg(CSC_A_CTRL, 32'hB);
    xreg("pulse mode", CSC_A_STATUS, 32'h8, 32'h0);
    wreg(CSC_A_CFG, 32'h6);
    wreg(CSC_A_CTRL, 32'h3);
    xreg("long sample", CSC_A_STATUS, 32'h8, 32'h0);
  endtask
  task automatic t_hang();
    wreg(CSC_A_CTRL, 32'h1C080);
    wreg(CSC_A_CTRL, 32'h10080);
    xreg("even divider", CSC_A_STATUS, 32'h4, 32'h0);
    wreg(CSC_A_CTRL, 32'h2C080);
    wreg(CSC_A_CTRL, 32'h20080);
    xreg("odd divider", CSC_A_STATUS, 32'h4, 32'h4);
    do_reset();
    xreg("hang reset", CSC_A_STATUS, 32'h4, 32'h0);
  endtask
  // timer period 256 clocks, far above one conversion
  task automatic t_timer();
    do_reset();
    wreg(CSC_A_CFG, 32'h6);
    wreg(CSC_A_CTRL, 32'h13);
    wreg(CSC_A_TIMER, 32'h100FF);
    repeat (290) @(posedge clk);
    wreg(CSC_A_TIMER, 32'hFF);
    wreg(CSC_A_CTRL, 32'h2);
    wreg(CSC_A_CTRL, 32'h7);
    xreg("wedge", CSC_A_STATUS, 32'h3, 32'h3);
    wreg(CSC_A_CTRL, 32'h0);
    wreg(CSC_A_CTRL, 32'h13);
    wreg(CSC_A_TIMER, 32'h100FF);
    repeat (290) @(posedge clk);
    wreg(CSC_A_TIMER, 32'hFF);
    wreg(CSC_A_CTRL, 32'h12);
    wreg(CSC_A_CTRL, 32'h13);
    wreg(CSC_A_TIMER, 32'h100FF);
    repeat (290) @(posedge clk);
    xreg("toggled trigger", CSC_A_STATUS, 32'h3, 32'h0);
    repeat (270) @(posedge clk);
    xreg("untoggled trigger", CSC_A_STATUS, 32'h2, 32'h2);
    wreg(CSC_A_TIMER, 32'hFF);
  endtask
  task automatic t_stuck();
    int d0;
    do_reset();
    wreg(CSC_A_CFG, 32'h6);
    wreg(CSC_A_CTRL, 32'h3);
    wreg(CSC_A_CTRL, 32'h7);
    wait_idle();
    xreg("cpu result", CSC_A_RESULT, 32'hFFF, 32'hA5C);
    wreg(CSC_A_CTRL, 32'h23);
    xreg("stuck set", CSC_A_STATUS, 32'h10, 32'h10);
    d0 = n_dma;
    wreg(CSC_A_CTRL, 32'h27);
    wait_idle();
    chk("edge dma count", 32'd0, n_dma - d0);
    wreg(CSC_A_CTRL, 32'h63);
    wreg(CSC_A_CTRL, 32'h67);
    wait_idle();
    chk("level dma count", 32'd1, n_dma - d0);
    chk("dma data", 32'hA5C, {20'h0, dmad});
    xreg("stuck clear", CSC_A_STATUS, 32'h10, 32'h0);
    wreg(CSC_A_CTRL, 32'h62);
    wait_idle();
    wreg(CSC_A_CTRL, 32'h60);
    xreg("quiet power off", CSC_A_STATUS, 32'h2, 32'h0);
  endtask
  initial begin
    do_reset();
    t_single();
    t_seq();
    t_overrun();
    t_pon();
    t_suspect();
    t_hang();
    t_timer();
    t_stuck();
    report_and_stop();
  end
endmodule
